// ### verification/bridge_drive_command_logic_monitor.sv
`timescale 1ns/10ps
module bridge_drive_command_logic_monitor (
	input wire aclk,
	input wire aresetn,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_rvalid,
	input wire phase_a_high_cmd,
	input wire phase_a_low_cmd,
	input wire sleep,
	input wire enable_in,
	input wire [5:0] gate_out,
	input wire slew_control_enable,
	input wire bridge_switch_on,
	input wire enable_timeout_flag
);
	reg [31:0] cfg;
	// shadow of the drive configuration word
	always @(posedge aclk) begin
		if (!aresetn)
			cfg <= 32'h0;
		else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			&& s_axi_awaddr == 32'h4)
			cfg <= s_axi_wdata;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	lockout_hold_a: assert property ((gate_out & {gate_out[4:0], 1'b0} & 6'h2a) == 6'h0)
		else $error("high and low drive of one phase on together");
	both_requested_a: assert property (phase_a_high_cmd && phase_a_low_cmd |=> gate_out[1:0] == 2'h0)
		else $error("phase a not forced low");
	direct_cutoff_a: assert property (cfg[8] && !enable_in |-> gate_out == 6'h0)
		else $error("direct enable did not cut outputs");
	fault_stop_a: assert property ($rose(enable_timeout_flag) && cfg[9] |-> ##[0:2] gate_out == 6'h0)
		else $error("timeout did not stop outputs");
	switch_off_a: assert property (sleep || !cfg[11] |=> !bridge_switch_on)
		else $error("bridge switch on while off requested");
	slew_mode_a: assert property (cfg[5:0] == 6'h0 |=> !slew_control_enable)
		else $error("slew control with zero dead time");
	flag_sticky_a: assert property (enable_timeout_flag && !s_axi_arvalid && !s_axi_rvalid |=> enable_timeout_flag)
		else $error("timeout flag cleared without read");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
endmodule
bind bridge_drive_command_logic bridge_drive_command_logic_monitor mon (.*);

// ### verification/bridge_drive_command_logic_tb.sv
`timescale 1ns/10ps
`include "bridge_drive_regs.vh"
module bridge_drive_command_logic_tb;
	logic aclk = 1'h0, aresetn = 1'h0, sleep = 1'h0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, enable_in, slew_control_enable;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic phase_a_high_cmd, phase_a_low_cmd, phase_b_high_cmd, phase_b_low_cmd;
	logic phase_c_high_cmd, phase_c_low_cmd, bridge_switch_on, zc_mux_out;
	logic enable_timeout_flag, rotation_direction;
	logic [5:0] req = 6'h0, ph, gate_out;
	logic [7:0] period = 8'h0;
	logic [2:0] zc_comp = 3'h0;
	int err_total = 0, num_checks = 0, n, k;
	always #20 aclk = ~aclk;
	assign {phase_c_low_cmd, phase_c_high_cmd, phase_b_low_cmd, phase_b_high_cmd,
		phase_a_low_cmd, phase_a_high_cmd} = ph;
	mcu_model mcu (.aclk(aclk), .req(req), .period(period), .phase(ph), .enable_in(enable_in));
	bridge_drive_command_logic #(.TIMEOUT_CYCLES(20), .FILT_UNIT_CYCLES(4)) dut (.*);
	task cyc(input int c);
		repeat (c) @(posedge aclk);
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		logic aw_pend, w_pend;
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		aw_pend = 1'h1;
		w_pend = 1'h1;
		while (aw_pend || w_pend) begin
			@(posedge aclk);
			if (aw_pend && s_axi_awready) begin
				s_axi_awvalid <= 1'h0;
				aw_pend = 1'h0;
			end
			if (w_pend && s_axi_wready) begin
				s_axi_wvalid <= 1'h0;
				w_pend = 1'h0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		rr = s_axi_bresp;
		s_axi_bready <= 1'h0;
		@(posedge aclk);
	endtask
	task rdr(input [7:0] a);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge aclk); while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'h0;
		@(posedge aclk);
	endtask
	task t_regs;
		rdr(`ADDR_BRIDGE_CTRL); chk(rd, `BRIDGE_CTRL_RESET);
		rdr(`ADDR_DRIVE_CFG); chk(rd, `DRIVE_CFG_RESET);
		rdr(`ADDR_ZC_CFG); chk(rd, `ZC_CFG_RESET);
		rdr(8'h14); chk(rr, `RESP_SLVERR);
		wr(8'h14, 32'h0); chk(rr, `RESP_SLVERR);
		wr(`ADDR_ZC_CFG, 32'h0); chk(rr, `RESP_OKAY);
	endtask
	task t_dead;
		int dts[4] = '{0, 1, 2, 24};
		// zero field: only the one-cycle register lag, no inserted gap
		int gap[4] = '{1, 3, 3, 30};
		for (k = 0; k < 4; k++) begin
			wr(`ADDR_DRIVE_CFG, 32'h100 | dts[k]);
			req <= 6'h01;
			cyc(60);
			req <= 6'h02;
			do @(posedge aclk); while (gate_out[0]);
			n = 0;
			while (!gate_out[1]) begin
				@(posedge aclk);
				n++;
			end
			chk(n, gap[k]);
			chk(slew_control_enable, dts[k] != 0);
			req <= 6'h0;
			cyc(60);
			req <= 6'h02;
			cyc(3);
			chk(gate_out, 6'h02);
		end
		chk(bridge_switch_on, 1'h0);
	endtask
	task t_direct;
		wr(`ADDR_DRIVE_CFG, 32'h900);
		cyc(2); chk(bridge_switch_on, 1'h1);
		sleep <= 1'h1;
		cyc(2); chk(bridge_switch_on, 1'h0);
		sleep <= 1'h0;
		for (k = 0; k < 6; k++) begin
			req <= 6'h1 << k;
			cyc(4); chk(gate_out, 6'h1 << k);
		end
		req <= 6'h0;
		wr(`ADDR_BRIDGE_CTRL, 32'h4);
		cyc(3); chk(gate_out, 6'h04);
		req <= 6'h38;
		cyc(3); chk(gate_out, 6'h0);
		wr(`ADDR_BRIDGE_CTRL, 32'h0);
		req <= 6'h01;
		cyc(3);
		period <= 8'h3;
		repeat (8) begin
			@(posedge aclk); chk(gate_out[0], enable_in);
		end
		period <= 8'h0;
	endtask
	task t_timed;
		wr(`ADDR_DRIVE_CFG, 32'h200);
		period <= 8'h5;
		cyc(15); chk(gate_out, 6'h01); chk(enable_timeout_flag, 1'h0);
		period <= 8'h0;
		cyc(30); chk(enable_timeout_flag, 1'h1); chk(gate_out, 6'h0);
		period <= 8'h5;
		cyc(12); chk(gate_out, 6'h01);
		wr(`ADDR_DRIVE_CFG, 32'h600);
		rdr(`ADDR_STATUS); chk(rd[0], 1'h1);
		cyc(2); chk(enable_timeout_flag, 1'h1);
		wr(`ADDR_DRIVE_CFG, 32'h0);
		rdr(`ADDR_STATUS);
		cyc(2); chk(enable_timeout_flag, 1'h0);
		period <= 8'h0;
		cyc(30); chk(enable_timeout_flag, 1'h1); chk(gate_out, 6'h01);
	endtask
	task t_zc;
		wr(`ADDR_ZC_CFG, 32'h12);
		zc_comp <= 3'h2;
		cyc(20);
		zc_comp <= 3'h3;
		cyc(3);
		zc_comp <= 3'h2;
		cyc(20); chk(zc_mux_out, 1'h0);
		zc_comp <= 3'h3;
		cyc(20); chk(zc_mux_out, 1'h1); chk(rotation_direction, 1'h1);
		for (k = 0; k < 8; k++) begin
			wr(`ADDR_ZC_CFG, 32'h2 | (k << 4));
			cyc(3); chk(zc_mux_out, (5'h06 >> k) & 1);
		end
		zc_comp <= 3'h0;
		cyc(20);
		zc_comp <= 3'h1;
		cyc(20); chk(rotation_direction, 1'h0);
	endtask
	task summarize;
		$display("mismatches %0d comparisons %0d", err_total, num_checks);
		if (err_total == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		cyc(20000);
		err_total++;
		summarize;
	end
	initial begin
		cyc(12);
		aresetn <= 1'h1;
		cyc(1);
		t_regs;
		t_dead;
		t_direct;
		t_timed;
		t_zc;
		summarize;
	end
endmodule

// ### verification/mcu_model.sv
`timescale 1ns/10ps
module mcu_model (
	input wire aclk,
	input wire [5:0] req,
	input wire [7:0] period,
	output logic [5:0] phase = 6'h0,
	output logic enable_in = 1'h1
);
	logic [7:0] cnt = 8'h0;
	always @(posedge aclk) begin
		// complementary gaps come from how the bench sequences req
		phase <= req;
		cnt <= (period == 8'h0 || cnt + 8'h1 == period) ? 8'h0 : cnt + 8'h1;
		if (period != 8'h0 && cnt + 8'h1 == period)
			enable_in <= ~enable_in;
	end
endmodule

// ### verilog/bridge_drive_command_logic.v
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "bridge_drive_regs.vh"
// Behaviour
// - dead time is field times 50 ns
// - field one or two gives 100 ns
// - zero field disables timer, lockout stays
// - zero dead time forces switched gate mode
// - delay turn-on only near complementary turn-off
// - six direct inputs drive six gates
// - gate command is input OR register bit
// - both sides requested forces phase low
// - mask one: enable gates outputs directly
// - mask zero: first edge enables, starts timer
// - timeout with stop bit drives low, flags
// - later enable edge reactivates, clears shutdown
// - timeout without stop: outputs kept, flag latched
// - flags clear on read unless suppress set or timeout persists
// - bridge switch off in sleep or bit zero
// - each comparator debounced by programmed time
// - mux select: xor, phase A/B/C, low
// - rotation direction readable in status
module bridge_drive_command_logic #(
	parameter TIMEOUT_CYCLES = 50000,
	parameter FILT_UNIT_CYCLES = 25
) (
	input wire aclk,
	input wire aresetn,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire phase_a_high_cmd,
	input wire phase_a_low_cmd,
	input wire phase_b_high_cmd,
	input wire phase_b_low_cmd,
	input wire phase_c_high_cmd,
	input wire phase_c_low_cmd,
	input wire enable_in,
	input wire sleep,
	input wire [2:0] zc_comp,
	output wire [5:0] gate_out,
	output reg slew_control_enable,
	output reg bridge_switch_on,
	output reg zc_mux_out,
	output reg enable_timeout_flag,
	output reg rotation_direction
);
	localparam [11:0] DEAD_UNIT_NS12 = `DEAD_UNIT_NS;
	localparam [11:0] CLK_NS12 = `CLK_PERIOD_NS;
	localparam [8:0] DEAD_MIN_CYC = (`DEAD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

	reg [5:0] bridge_ctrl;
	reg [31:0] drive_cfg;
	reg [31:0] zc_cfg;
	reg [31:0] aw_addr;
	reg aw_held;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg w_held;

	wire [5:0] dead_time_count = drive_cfg[`DEAD_MSB:`DEAD_LSB];
	wire timeout_direct = drive_cfg[`TMO_MASK_BIT];
	wire stop_on_fault = drive_cfg[`FAULT_STOP_BIT];
	wire diag_reset_suppress = drive_cfg[`DSR_BIT];
	wire [3:0] zc_filter_time = zc_cfg[`FILT_MSB:`FILT_LSB];
	wire [2:0] zc_mux_select = zc_cfg[`MUX_MSB:`MUX_LSB];

	function [31:0] merge_bytes;
		input [31:0] old_value;
		input [31:0] new_value;
		input [3:0] strb;
		integer i;
		begin
			merge_bytes = old_value;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					merge_bytes[i*8 +: 8] = new_value[i*8 +: 8];
			end
		end
	endfunction

	// write channel: address and data taken in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	wire aw_now = aw_held || s_axi_awvalid;
	wire w_now = w_held || s_axi_wvalid;
	wire [31:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
	wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
	wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
	wire do_write = aw_now && w_now && !s_axi_bvalid;
	wire [7:0] wr_off = {wr_addr[7:2], 2'b00};
	wire [31:0] bridge_merged = merge_bytes({26'h0, bridge_ctrl}, wr_data, wr_strb);

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 32'h00000000;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			bridge_ctrl <= 6'h00;
			drive_cfg <= `DRIVE_CFG_RESET;
			zc_cfg <= `ZC_CFG_RESET;
		end else begin
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RESP_OKAY;
				if (wr_addr[31:8] != 24'h000000) begin
					s_axi_bresp <= `RESP_SLVERR;
				end else if (wr_off == `ADDR_BRIDGE_CTRL) begin
					bridge_ctrl <= bridge_merged[5:0];
				end else if (wr_off == `ADDR_DRIVE_CFG) begin
					drive_cfg <= merge_bytes(drive_cfg, wr_data, wr_strb) & 32'h00000f3f;
				end else if (wr_off == `ADDR_ZC_CFG) begin
					zc_cfg <= merge_bytes(zc_cfg, wr_data, wr_strb) & 32'h0000007f;
				end else if (wr_off != `ADDR_STATUS && wr_off != `ADDR_VERIFY) begin
					s_axi_bresp <= `RESP_SLVERR;
				end
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_held <= 1'b1;
					aw_addr <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_held <= 1'b1;
					w_data <= s_axi_wdata;
					w_strb <= s_axi_wstrb;
				end
			end
		end
	end

	// read channel
	assign s_axi_arready = !s_axi_rvalid;
	wire do_read = s_axi_arvalid && !s_axi_rvalid;
	wire [7:0] rd_off = {s_axi_araddr[7:2], 2'b00};
	wire status_read = do_read && s_axi_araddr[31:8] == 24'h000000 && rd_off == `ADDR_STATUS;

	// dead-time length in cycles, zero when timer disabled
	// product in ns rounded up to whole clocks, so 24 gives 30 cycles
	wire [11:0] dt_ns = {6'h00, dead_time_count} * DEAD_UNIT_NS12;
	wire [11:0] dt_div = (dt_ns + CLK_NS12 - 12'h001) / CLK_NS12;
	wire [8:0] dt_prod = dt_div[8:0];
	wire [8:0] dt_cycles = (dead_time_count == 6'h00) ? 9'h000 :
		(dead_time_count <= 6'h02) ? DEAD_MIN_CYC : dt_prod;

	// merge, lockout, dead time per phase
	wire [5:0] direct_in = {phase_c_low_cmd, phase_c_high_cmd, phase_b_low_cmd,
		phase_b_high_cmd, phase_a_low_cmd, phase_a_high_cmd};
	wire [5:0] request = direct_in | bridge_ctrl;
	reg [5:0] locked;
	reg [5:0] drive;
	reg [8:0] off_timer [0:5];
	integer p;
	integer q;
	always @* begin
		for (p = 0; p < 3; p = p + 1) begin
			if (request[2*p] && request[2*p+1])
				locked[2*p +: 2] = 2'b00;
			else
				locked[2*p +: 2] = request[2*p +: 2];
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			drive <= 6'h00;
			for (q = 0; q < 6; q = q + 1)
				off_timer[q] <= 9'h000;
		end else begin
			for (q = 0; q < 6; q = q + 1) begin
				if (drive[q] && !locked[q]) begin
					drive[q] <= 1'b0;
					off_timer[q] <= dt_cycles;
				end else begin
					if (off_timer[q] != 9'h000)
						off_timer[q] <= off_timer[q] - 9'h001;
					// turn-on waits while partner is still driven or its off timer is above one
					if (locked[q] && off_timer[q ^ 1] <= 9'h001 && !drive[q ^ 1])
						drive[q] <= 1'b1;
				end
			end
		end
	end

	// enable: direct or timed
	reg enable_prev;
	reg enable_seen;
	reg timed_active;
	reg timed_shutdown;
	reg [31:0] timeout_count;
	// first cycle after reset only samples the pin: its idle level is no edge
	wire enable_edge = enable_seen && (enable_in ^ enable_prev);
	wire timeout_hit = timed_active && timeout_count == TIMEOUT_CYCLES - 1;
	always @(posedge aclk) begin
		if (!aresetn) begin
			enable_prev <= 1'b0;
			enable_seen <= 1'b0;
			timed_active <= 1'b0;
			timed_shutdown <= 1'b0;
			timeout_count <= 32'h00000000;
			enable_timeout_flag <= 1'b0;
		end else begin
			enable_prev <= enable_in;
			enable_seen <= 1'b1;
			if (timeout_direct) begin
				timed_active <= 1'b0;
				timed_shutdown <= 1'b0;
				timeout_count <= 32'h00000000;
			end else if (enable_edge) begin
				timed_active <= 1'b1;
				timed_shutdown <= 1'b0;
				timeout_count <= 32'h00000000;
			end else if (timed_active) begin
				if (timeout_hit) begin
					if (stop_on_fault)
						timed_shutdown <= 1'b1;
				end else begin
					timeout_count <= timeout_count + 32'h00000001;
				end
			end
			if (!timeout_direct && !enable_edge && timeout_hit)
				enable_timeout_flag <= 1'b1;
			else if (status_read && !diag_reset_suppress)
				enable_timeout_flag <= 1'b0;
		end
	end

	wire outputs_allowed = timeout_direct ? enable_in : (timed_active && !timed_shutdown);
	assign gate_out = drive & {6{outputs_allowed}};

	// comparators and mux
	wire [2:0] zc_filt;
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : zc
			zc_debounce #(
				.UNIT_CYCLES(FILT_UNIT_CYCLES)
			) u_deb (
				.aclk(aclk),
				.aresetn(aresetn),
				.raw(zc_comp[g]),
				.filter_time(zc_filter_time),
				.filtered(zc_filt[g])
			);
		end
	endgenerate
	wire speed_pulse = ^zc_filt;
	reg [2:0] zc_prev;
	always @(posedge aclk) begin
		if (!aresetn) begin
			zc_mux_out <= 1'b0;
			bridge_switch_on <= 1'b0;
			slew_control_enable <= 1'b0;
			rotation_direction <= 1'b0;
			zc_prev <= 3'h0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			if (zc_mux_select[2])
				zc_mux_out <= 1'b0;
			else if (zc_mux_select[1:0] == 2'b00)
				zc_mux_out <= speed_pulse;
			else
				zc_mux_out <= zc_filt[zc_mux_select[1:0] - 2'b01];
			bridge_switch_on <= drive_cfg[`BRIDGE_SW_BIT] && !sleep;
			slew_control_enable <= dead_time_count != 6'h00;
			zc_prev <= zc_filt;
			// rising edge of A: B high means forward
			if (zc_filt[0] && !zc_prev[0])
				rotation_direction <= zc_filt[1];
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (do_read) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RESP_OKAY;
				s_axi_rdata <= 32'h00000000;
				if (s_axi_araddr[31:8] != 24'h000000)
					s_axi_rresp <= `RESP_SLVERR;
				else if (rd_off == `ADDR_BRIDGE_CTRL)
					s_axi_rdata <= {26'h0, bridge_ctrl};
				else if (rd_off == `ADDR_DRIVE_CFG)
					s_axi_rdata <= drive_cfg;
				else if (rd_off == `ADDR_ZC_CFG)
					s_axi_rdata <= zc_cfg;
				else if (rd_off == `ADDR_STATUS)
					s_axi_rdata <= {22'h0, gate_out, timed_shutdown, timed_active,
						rotation_direction, enable_timeout_flag};
				else if (rd_off == `ADDR_VERIFY)
					s_axi_rdata <= {28'h0, zc_filt, rotation_direction};
				else
					s_axi_rresp <= `RESP_SLVERR;
			end
		end
	end
endmodule

// ### verilog/bridge_drive_regs.vh
`ifndef BRIDGE_DRIVE_REGS_VH
`define BRIDGE_DRIVE_REGS_VH
`define ADDR_BRIDGE_CTRL 8'h00
`define ADDR_DRIVE_CFG 8'h04
`define ADDR_ZC_CFG 8'h08
`define ADDR_STATUS 8'h0c
`define ADDR_VERIFY 8'h10
`define BRIDGE_CTRL_RESET 32'h00000000
`define DRIVE_CFG_RESET 32'h00000000
`define ZC_CFG_RESET 32'h00000000
`define DEAD_LSB 0
`define DEAD_MSB 5
`define TMO_MASK_BIT 8
`define FAULT_STOP_BIT 9
`define DSR_BIT 10
`define BRIDGE_SW_BIT 11
`define FILT_LSB 0
`define FILT_MSB 3
`define MUX_LSB 4
`define MUX_MSB 6
`define DEAD_UNIT_NS 50
`define DEAD_MIN_NS 100
`define CLK_PERIOD_NS 40
`define FILT_UNIT_NS 1000
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ### verilog/zc_debounce.v
`timescale 1ns/10ps
`include "bridge_drive_regs.vh"
module zc_debounce #(
	parameter UNIT_CYCLES = 25
) (
	input wire aclk,
	input wire aresetn,
	input wire raw,
	input wire [3:0] filter_time,
	output reg filtered
);
	reg [11:0] count;
	wire [11:0] limit = filter_time * UNIT_CYCLES[7:0];
	always @(posedge aclk) begin
		if (!aresetn) begin
			count <= 12'h000;
			filtered <= 1'b0;
		end else if (raw == filtered) begin
			count <= 12'h000;
		end else if (count + 12'h001 >= limit) begin
			filtered <= raw;
			count <= 12'h000;
		end else begin
			count <= count + 12'h001;
		end
	end
endmodule
